//--- hdl/rpf_pkg.sv
// Functional notes
// - Window 1 base low word at 50h.
// - Window 1 base high word at offset 54h.
// - Window 1 size from bits 31:1 of 58h.
// - Polarity clear: reads inside window 1 denied unless inside window 2.
// - Polarity set: only reads inside window 1 or window 2 allowed.
// - Window 2 base low at 5Ch; mode-qualified.
// - Window 2 base high word at offset 60h.
// - Window 2 size, all bits of 64h.
`default_nettype none
package rpf_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] OFF_RSVD_A = 8'h4c;
    localparam logic [ADDR_W-1:0] OFF_W1_BASE_LO = 8'h50;
    localparam logic [ADDR_W-1:0] OFF_W1_BASE_HI = 8'h54;
    localparam logic [ADDR_W-1:0] OFF_W1_SIZE_POL = 8'h58;
    localparam logic [ADDR_W-1:0] OFF_W2_BASE_LO = 8'h5c;
    localparam logic [ADDR_W-1:0] OFF_W2_BASE_HI = 8'h60;
    localparam logic [ADDR_W-1:0] OFF_W2_SIZE = 8'h64;
    localparam logic [ADDR_W-1:0] OFF_PERMIT_CNT = 8'h80;
    localparam logic [ADDR_W-1:0] OFF_DENY_CNT = 8'h84;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h88;

    // ****************************************************************
    // Reset values and field positions
    // ****************************************************************
    localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;
    localparam int POL_BIT = 0;
    localparam int SIZE_LSB = 1;
    localparam int ST_MODE_BIT = 0;
    localparam int ST_ALLOW_BIT = 1;
    localparam int ST_HIT1_BIT = 2;
    localparam int ST_HIT2_BIT = 3;
    localparam int ST_VALID_BIT = 4;
    localparam int CNT_W = 16;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic valid;
        logic memread;
        logic [63:0] addr;
    } rpf_req_t;

    typedef struct packed {
        logic valid;
        logic allow;
        logic hit1;
        logic hit2;
    } rpf_dec_t;

endpackage : rpf_pkg
`default_nettype wire

//--- hdl/rpf_window_match.sv
`timescale 1ns/1ps
`default_nettype none
// Compares one read address against one window, base inclusive, end exclusive.
module rpf_window_match #(
    parameter int ADDR_BITS = 64,
    parameter int SIZE_BITS = 32
) (
    // Window description.
    input wire logic [ADDR_BITS-1:0] base_i,
    input wire logic [SIZE_BITS-1:0] size_i,
    // Address under test.
    input wire logic [ADDR_BITS-1:0] addr_i,
    // Result.
    output logic hit_o
);

    // The end is one bit wider so a window touching the top of the space does not wrap.
    logic [ADDR_BITS:0] win_end;
    logic above_base;
    logic below_end;

    // A zero size gives an empty window, which never hits.
    assign win_end = {1'b0, base_i} + {{(ADDR_BITS + 1 - SIZE_BITS){1'b0}}, size_i};
    assign above_base = (addr_i >= base_i);
    assign below_end = ({1'b0, addr_i} < win_end);
    assign hit_o = above_base & below_end;

endmodule : rpf_window_match
`default_nettype wire

//--- hdl/rpf_event_counter.sv
`timescale 1ns/1ps
`default_nettype none
// Saturating event counter with a software clear.
module rpf_event_counter #(
    parameter int WIDTH = 16
) (
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    // Control.
    input wire logic clear_i,
    input wire logic inc_i,
    // Count.
    output logic [WIDTH-1:0] count_o
);

    logic [WIDTH-1:0] count_r;
    logic [WIDTH-1:0] count_nxt;
    logic at_max;
    logic [WIDTH-1:0] base_val;

    // An event in the clearing cycle is not lost: it counts from zero.
    assign at_max = &count_r;
    assign base_val = clear_i ? '0 : count_r;
    assign count_nxt = (inc_i && !(at_max && !clear_i)) ? base_val + 1'b1 : base_val;

    // Count register.
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            count_r <= '0;
        end else begin
            count_r <= count_nxt;
        end
    end

    assign count_o = count_r;

endmodule : rpf_event_counter
`default_nettype wire

//--- hdl/rpf_range_filter.sv
`timescale 1ns/1ps
`default_nettype none
// Address-range filter that decides whether a memory read may use smart read prefetch.
module rpf_range_filter #(
    parameter int CNT_WIDTH = rpf_pkg::CNT_W
) (
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    // Register port.
    input wire logic [rpf_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [rpf_pkg::DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [rpf_pkg::DATA_W-1:0] reg_rdata_o,
    // Mode qualifier from the mode-control field outside this block.
    input wire logic smart_mode_en_i,
    // Read request and decision.
    input wire rpf_pkg::rpf_req_t req_i,
    output rpf_pkg::rpf_dec_t dec_o
);

    // ****************************************************************
    // Register storage
    // ****************************************************************
    logic [rpf_pkg::DATA_W-1:0] w1_base_lo_r;
    logic [rpf_pkg::DATA_W-1:0] w1_base_hi_r;
    logic [rpf_pkg::DATA_W-1:0] w1_size_pol_r;
    logic [rpf_pkg::DATA_W-1:0] w2_base_lo_r;
    logic [rpf_pkg::DATA_W-1:0] w2_base_hi_r;
    logic [rpf_pkg::DATA_W-1:0] w2_size_r;
    logic [rpf_pkg::DATA_W-1:0] rdata_r;
    logic [rpf_pkg::DATA_W-1:0] rdata_nxt;
    rpf_pkg::rpf_dec_t dec_r;
    rpf_pkg::rpf_dec_t dec_nxt;

    // ****************************************************************
    // Address decode
    // ****************************************************************
    logic sel_w1_lo;
    logic sel_w1_hi;
    logic sel_w1_sp;
    logic sel_w2_lo;
    logic sel_w2_hi;
    logic sel_w2_sz;
    logic sel_permit;
    logic sel_deny;
    logic sel_status;

    // One select per mapped word; the reserved word and holes decode to nothing.
    assign sel_w1_lo = (reg_addr_i == rpf_pkg::OFF_W1_BASE_LO);
    assign sel_w1_hi = (reg_addr_i == rpf_pkg::OFF_W1_BASE_HI);
    assign sel_w1_sp = (reg_addr_i == rpf_pkg::OFF_W1_SIZE_POL);
    assign sel_w2_lo = (reg_addr_i == rpf_pkg::OFF_W2_BASE_LO);
    assign sel_w2_hi = (reg_addr_i == rpf_pkg::OFF_W2_BASE_HI);
    assign sel_w2_sz = (reg_addr_i == rpf_pkg::OFF_W2_SIZE);
    assign sel_permit = (reg_addr_i == rpf_pkg::OFF_PERMIT_CNT);
    assign sel_deny = (reg_addr_i == rpf_pkg::OFF_DENY_CNT);
    assign sel_status = (reg_addr_i == rpf_pkg::OFF_STATUS);

    // Write enables.
    logic wr_w1_lo;
    logic wr_w1_hi;
    logic wr_w1_sp;
    logic wr_w2_lo;
    logic wr_w2_hi;
    logic wr_w2_sz;
    logic clr_permit;
    logic clr_deny;

    assign wr_w1_lo = reg_wr_i & sel_w1_lo;
    assign wr_w1_hi = reg_wr_i & sel_w1_hi;
    assign wr_w1_sp = reg_wr_i & sel_w1_sp;
    assign wr_w2_lo = reg_wr_i & sel_w2_lo;
    assign wr_w2_hi = reg_wr_i & sel_w2_hi;
    assign wr_w2_sz = reg_wr_i & sel_w2_sz;
    assign clr_permit = reg_wr_i & sel_permit;
    assign clr_deny = reg_wr_i & sel_deny;

    // ****************************************************************
    // Window registers
    // ****************************************************************

    // Window 1 base, low word.
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            w1_base_lo_r <= rpf_pkg::RST_WORD;
        end else if (wr_w1_lo) begin
            w1_base_lo_r <= reg_wdata_i;
        end
    end

    // Window 1 base, high word.
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            w1_base_hi_r <= rpf_pkg::RST_WORD;
        end else if (wr_w1_hi) begin
            w1_base_hi_r <= reg_wdata_i;
        end
    end

    // Window 1 size and polarity share one word; the polarity resets to exclude.
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            w1_size_pol_r <= rpf_pkg::RST_WORD;
        end else if (wr_w1_sp) begin
            w1_size_pol_r <= reg_wdata_i;
        end
    end

    // Window 2 base, low word.
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            w2_base_lo_r <= rpf_pkg::RST_WORD;
        end else if (wr_w2_lo) begin
            w2_base_lo_r <= reg_wdata_i;
        end
    end

    // Window 2 base, high word.
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            w2_base_hi_r <= rpf_pkg::RST_WORD;
        end else if (wr_w2_hi) begin
            w2_base_hi_r <= reg_wdata_i;
        end
    end

    // Window 2 size.
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            w2_size_r <= rpf_pkg::RST_WORD;
        end else if (wr_w2_sz) begin
            w2_size_r <= reg_wdata_i;
        end
    end

    // ****************************************************************
    // Window compare
    // ****************************************************************
    logic [63:0] w1_base;
    logic [63:0] w2_base;
    logic [rpf_pkg::DATA_W-1:0] w1_size;
    logic w1_polarity;
    logic hit1;
    logic hit2;

    // Window 1 size ignores bit 0, so it always has two-byte granularity.
    assign w1_base = {w1_base_hi_r, w1_base_lo_r};
    assign w2_base = {w2_base_hi_r, w2_base_lo_r};
    assign w1_size = {w1_size_pol_r[rpf_pkg::DATA_W-1:rpf_pkg::SIZE_LSB], 1'b0};
    assign w1_polarity = w1_size_pol_r[rpf_pkg::POL_BIT];

    rpf_window_match #(
        .ADDR_BITS(64),
        .SIZE_BITS(rpf_pkg::DATA_W)
    ) u_match_w1 (
        .base_i(w1_base),
        .size_i(w1_size),
        .addr_i(req_i.addr),
        .hit_o(hit1)
    );

    rpf_window_match #(
        .ADDR_BITS(64),
        .SIZE_BITS(rpf_pkg::DATA_W)
    ) u_match_w2 (
        .base_i(w2_base),
        .size_i(w2_size_r),
        .addr_i(req_i.addr),
        .hit_o(hit2)
    );

    // ****************************************************************
    // Decision
    // ****************************************************************
    logic w1_permits;
    logic window_permits;
    logic is_memread;

    // Window 1 either excludes its range or allows only its range, before window 2 is added.
    assign w1_permits = w1_polarity ? hit1 : ~hit1;
    // Window 2 can only widen what is allowed, since it has no polarity of its own.
    assign window_permits = w1_permits | hit2;
    assign is_memread = req_i.valid & req_i.memread;

    // Only memory reads in the selected smart read mode can be permitted.
    always_comb begin
        dec_nxt.valid = req_i.valid;
        dec_nxt.allow = is_memread & smart_mode_en_i & window_permits;
        dec_nxt.hit1 = req_i.valid & hit1;
        dec_nxt.hit2 = req_i.valid & hit2;
    end

    // The decision is registered, so it stands one cycle after the request.
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            dec_r <= '0;
        end else begin
            dec_r <= dec_nxt;
        end
    end

    assign dec_o = dec_r;

    // ****************************************************************
    // Statistics
    // ****************************************************************
    logic [CNT_WIDTH-1:0] permit_cnt;
    logic [CNT_WIDTH-1:0] deny_cnt;
    logic dec_memread_r;
    logic inc_permit;
    logic inc_deny;

    // Remember whether the decided request was a memory read.
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            dec_memread_r <= 1'b0;
        end else begin
            dec_memread_r <= is_memread;
        end
    end

    // Count memory-read decisions only; other requests never prefetch anyway.
    assign inc_permit = dec_r.valid & dec_memread_r & dec_r.allow;
    assign inc_deny = dec_r.valid & dec_memread_r & ~dec_r.allow;

    rpf_event_counter #(
        .WIDTH(CNT_WIDTH)
    ) u_permit_cnt (
        .ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .clear_i(clr_permit),
        .inc_i(inc_permit),
        .count_o(permit_cnt)
    );

    rpf_event_counter #(
        .WIDTH(CNT_WIDTH)
    ) u_deny_cnt (
        .ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .clear_i(clr_deny),
        .inc_i(inc_deny),
        .count_o(deny_cnt)
    );

    // ****************************************************************
    // Read path
    // ****************************************************************
    logic [rpf_pkg::DATA_W-1:0] status_word;
    logic [rpf_pkg::DATA_W-1:0] permit_word;
    logic [rpf_pkg::DATA_W-1:0] deny_word;
    logic [rpf_pkg::DATA_W-1:0] rd_mux;

    // Status shows the mode input and the latest decision.
    always_comb begin
        status_word = rpf_pkg::RST_WORD;
        status_word[rpf_pkg::ST_MODE_BIT] = smart_mode_en_i;
        status_word[rpf_pkg::ST_ALLOW_BIT] = dec_r.allow;
        status_word[rpf_pkg::ST_HIT1_BIT] = dec_r.hit1;
        status_word[rpf_pkg::ST_HIT2_BIT] = dec_r.hit2;
        status_word[rpf_pkg::ST_VALID_BIT] = dec_r.valid;
    end

    assign permit_word = {{(rpf_pkg::DATA_W - CNT_WIDTH){1'b0}}, permit_cnt};
    assign deny_word = {{(rpf_pkg::DATA_W - CNT_WIDTH){1'b0}}, deny_cnt};

    // AND-OR select; the reserved word and unmapped offsets read as zero.
    assign rd_mux = ({rpf_pkg::DATA_W{sel_w1_lo}} & w1_base_lo_r)
                  | ({rpf_pkg::DATA_W{sel_w1_hi}} & w1_base_hi_r)
                  | ({rpf_pkg::DATA_W{sel_w1_sp}} & w1_size_pol_r)
                  | ({rpf_pkg::DATA_W{sel_w2_lo}} & w2_base_lo_r)
                  | ({rpf_pkg::DATA_W{sel_w2_hi}} & w2_base_hi_r)
                  | ({rpf_pkg::DATA_W{sel_w2_sz}} & w2_size_r)
                  | ({rpf_pkg::DATA_W{sel_permit}} & permit_word)
                  | ({rpf_pkg::DATA_W{sel_deny}} & deny_word)
                  | ({rpf_pkg::DATA_W{sel_status}} & status_word);

    // Read data stand only in the cycle after the strobe, zero otherwise.
    assign rdata_nxt = reg_rd_i ? rd_mux : rpf_pkg::RST_WORD;

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_r <= rpf_pkg::RST_WORD;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata_o = rdata_r;

endmodule : rpf_range_filter
`default_nettype wire

//--- dv/rpf_range_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Port checker for the range filter
// ****************************************************************
module rpf_range_checker (
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    // Register port.
    input wire logic [rpf_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [rpf_pkg::DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [rpf_pkg::DATA_W-1:0] reg_rdata_o,
    // Request and decision.
    input wire logic smart_mode_en_i,
    input wire rpf_pkg::rpf_req_t req_i,
    input wire rpf_pkg::rpf_dec_t dec_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);

    logic [63:0] base1_r;
    logic [31:0] size1_r;
    logic pol_r;
    wire logic wr_lo = reg_wr_i && (reg_addr_i == rpf_pkg::OFF_W1_BASE_LO);
    wire logic wr_hi = reg_wr_i && (reg_addr_i == rpf_pkg::OFF_W1_BASE_HI);
    wire logic wr_sz = reg_wr_i && (reg_addr_i == rpf_pkg::OFF_W1_SIZE_POL);
    wire logic live = req_i.valid && req_i.memread && smart_mode_en_i;
    // End is one bit wider, so a window touching the top of memory never wraps.
    wire logic [64:0] end1 = {1'b0, base1_r} + {33'h0, size1_r[31:1], 1'b0};
    wire logic in1 = (req_i.addr >= base1_r) && ({1'b0, req_i.addr} < end1);

    // Shadow of window 1, so its range can be judged from the ports alone.
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            base1_r <= 64'h0;
            size1_r <= 32'h0;
            pol_r <= 1'b0;
        end else begin
            if (wr_lo) base1_r[31:0] <= reg_wdata_i;
            if (wr_hi) base1_r[63:32] <= reg_wdata_i;
            if (wr_sz) size1_r <= reg_wdata_i;
            if (wr_sz) pol_r <= reg_wdata_i[0];
        end
    end

    rdata_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
        else $error("read data not zero outside read cycle");
    dec_valid_a: assert property (1'b1 |=> dec_o.valid == $past(req_i.valid))
        else $error("decision not one cycle after request");
    mode_off_a: assert property (req_i.valid && !smart_mode_en_i |=> !dec_o.allow)
        else $error("permit while smart mode is off");
    non_read_a: assert property (req_i.valid && !req_i.memread |=> !dec_o.allow)
        else $error("permit for a non memory read");
    win2_incl_a: assert property (live |=> !dec_o.hit2 || dec_o.allow)
        else $error("window 2 hit not permitted");
    excl_win_a: assert property (live && !pol_r |=> dec_o.allow == (!dec_o.hit1 || dec_o.hit2))
        else $error("exclude polarity decision wrong");
    incl_win_a: assert property (live && pol_r |=> dec_o.allow == (dec_o.hit1 || dec_o.hit2))
        else $error("include polarity decision wrong");
    range1_a: assert property (req_i.valid |=> dec_o.hit1 == $past(in1))
        else $error("window 1 hit does not match range");
endmodule : rpf_range_checker
`default_nettype wire

//--- dv/rpf_master_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Bus master issuing one read request per call
// ****************************************************************
module rpf_master_model (
    // Clock.
    input wire logic ref_clk_i,
    // Request to the filter.
    output var rpf_pkg::rpf_req_t req_o
);
    initial req_o = '{valid: 1'b0, memread: 1'b0, addr: 64'h0};

    // Idle cycles show the inverted address, so a stale value never looks valid.
    task automatic issue(input logic [63:0] a, input logic mr);
        @(posedge ref_clk_i);
        req_o <= '{valid: 1'b1, memread: mr, addr: a};
        @(posedge ref_clk_i);
        req_o <= '{valid: 1'b0, memread: ~mr, addr: ~a};
    endtask : issue
endmodule : rpf_master_model
`default_nettype wire

//--- dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(act, exp) begin n_checks++; if ((act) !== (exp)) begin num_errors++; \
    $display("MISMATCH %0t got %h want %h", $time, act, exp); end end
// ****************************************************************
// Testbench top
// ****************************************************************
module tb_top;
    logic ref_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h0;
    logic [31:0] reg_wdata_i = 32'h0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [31:0] reg_rdata_o;
    logic smart_mode_en_i = 1'b0;
    rpf_pkg::rpf_req_t req_i;
    rpf_pkg::rpf_dec_t dec_o;
    int num_errors = 0;
    int n_checks = 0;
    logic [7:0] offs [6] = '{8'h50, 8'h54, 8'h58, 8'h5c, 8'h60, 8'h64};
    logic [63:0] b1 = 64'h0000_0001_0000_1000;
    logic [63:0] b2 = 64'h0000_0002_0000_0000;
    logic [63:0] addrs [8] = '{64'h0000_0001_0000_0fff, 64'h0000_0001_0000_1000,
        64'h0000_0001_0000_10ff, 64'h0000_0001_0000_1100, 64'h0000_0001_ffff_ffff,
        64'h0000_0002_0000_0000, 64'h0000_0002_0000_003f, 64'h0000_0002_0000_0040};
    logic h1;
    logic h2;
    logic al;
    int n_perm = 0;
    int n_deny = 0;

    always #12.5 ref_clk_i = ~ref_clk_i;

    rpf_range_filter i_dut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .smart_mode_en_i(smart_mode_en_i),
        .req_i(req_i), .dec_o(dec_o));
    rpf_master_model i_mst (.ref_clk_i(ref_clk_i), .req_o(req_i));

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe, so sample there.
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        #1;
        `CHK(reg_rdata_o, e)
    endtask : rd_chk

    // One request, then the decision in the following cycle.
    task automatic req_chk(input logic [63:0] a, input logic mr, input logic [3:0] e);
        i_mst.issue(a, mr);
        #1;
        `CHK(dec_o, e)
    endtask : req_chk

    task automatic summarize;
        $display("Checks %0d, mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : summarize

    // Main sequence.
    initial begin
        repeat (10) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        foreach (offs[i]) rd_chk(offs[i], 32'h0);
        foreach (offs[i]) wr(offs[i], 32'hc35a_0f00 + 32'(i));
        foreach (offs[i]) rd_chk(offs[i], 32'hc35a_0f00 + 32'(i));
        wr(8'h4c, 32'hffff_ffff);
        rd_chk(8'h4c, 32'h0);
        rd_chk(8'h90, 32'h0);
        wr(8'h50, b1[31:0]);
        wr(8'h54, b1[63:32]);
        wr(8'h5c, b2[31:0]);
        wr(8'h60, b2[63:32]);
        wr(8'h64, 32'h0000_0040);
        @(posedge ref_clk_i);
        smart_mode_en_i <= 1'b1;
        // No request has been decided yet, so only the mode bit shows.
        rd_chk(8'h88, 32'h1 << rpf_pkg::ST_MODE_BIT);
        // Bit 0 is polarity only: the odd size word must still give 100h bytes.
        for (int p = 0; p < 2; p++) begin
            wr(8'h58, 32'h0000_0100 | 32'(p));
            foreach (addrs[i]) begin
                h1 = addrs[i] >= b1 && addrs[i] < b1 + 64'h100;
                h2 = addrs[i] >= b2 && addrs[i] < b2 + 64'h40;
                al = ((p == 1) ? h1 : !h1) | h2;
                if (al) n_perm++;
                else n_deny++;
                req_chk(addrs[i], 1'b1, {1'b1, al, h1, h2});
            end
        end
        req_chk(b2, 1'b0, 4'b1001);
        @(posedge ref_clk_i);
        smart_mode_en_i <= 1'b0;
        req_chk(b1, 1'b1, 4'b1010);
        // Counters see memory reads only; the last one was denied with the mode off.
        rd_chk(8'h80, 32'(n_perm));
        rd_chk(8'h84, 32'(n_deny + 1));
        // Any write clears its own counter and leaves the other alone.
        wr(8'h80, 32'hffff_ffff);
        rd_chk(8'h80, 32'h0);
        rd_chk(8'h84, 32'(n_deny + 1));
        summarize();
    end

    // Watchdog: the sequence needs about 120 cycles.
    initial begin
        #100000;
        num_errors++;
        summarize();
    end
endmodule : tb_top

bind rpf_range_filter rpf_range_checker i_chk (.ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .smart_mode_en_i(smart_mode_en_i), .req_i(req_i), .dec_o(dec_o));
`default_nettype wire
